// >>> rtl/crs_defs.svh
// constants for the core register set
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_PC_W 16
`define CRS_DW 8
`define CRS_RESET_VEC_LO 16'hFFFE
`define CRS_RESET_VEC_HI 16'hFFFF
`define CRS_STACK_PAGE 8'h01
`define CRS_STACK_BOT 16'h0100
`define CRS_STACK_TOP 16'h015F
`define CRS_PROG_BYTES 8192
`define CRS_DATA_BYTES 1024
`define CRS_DISP_NIBBLES 27
`define CRS_PSW_C 0
`define CRS_PSW_Z 1
`define CRS_PSW_I 2
`define CRS_PSW_H 3
`define CRS_PSW_B 4
`define CRS_PSW_G 5
`define CRS_PSW_V 6
`define CRS_PSW_N 7
`define CRS_PSW_RST 8'h00
`endif

// >>> rtl/crs_pkg.sv
// types for the core register set
package crs_pkg;
	typedef enum logic [3:0] {
		CRS_OP_NONE = 4'h0,
		CRS_OP_LD = 4'h1,
		CRS_OP_INC = 4'h2,
		CRS_OP_DEC = 4'h3,
		CRS_OP_CMP = 4'h4,
		CRS_OP_PUSH = 4'h5,
		CRS_OP_POP = 4'h6,
		CRS_OP_LDW = 4'h7,
		CRS_OP_JMP = 4'h8,
		CRS_OP_STEP = 4'h9
	} crs_op_t;
	typedef enum logic [2:0] {
		CRS_R_A = 3'h0,
		CRS_R_X = 3'h1,
		CRS_R_Y = 3'h2,
		CRS_R_SP = 3'h3,
		CRS_R_PSW = 3'h4
	} crs_sel_t;
	typedef enum logic [1:0] {
		CRS_SP_PROG = 2'h0,
		CRS_SP_DATA = 2'h1,
		CRS_SP_DISP = 2'h2
	} crs_space_t;
	typedef enum logic [1:0] {
		CRS_ST_RESET = 2'h0,
		CRS_ST_VLO = 2'h1,
		CRS_ST_VHI = 2'h2,
		CRS_ST_RUN = 2'h3
	} crs_state_t;
	typedef struct packed {
		crs_op_t op;
		crs_sel_t sel;
		logic [7:0] data;
		logic [15:0] wide;
	} crs_cmd_t;
	typedef struct packed {
		crs_space_t space;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} crs_mem_req_t;
	typedef struct packed {
		crs_state_t st;
		logic [15:0] pc;
		logic [7:0] a;
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] sp;
		logic [7:0] processor_status_word;
		logic [7:0] vlo;
	} crs_state_s_t;
endpackage : crs_pkg

// >>> rtl/crs_mem_gate.sv
// address space gate: checks program, data and display accesses and accepts or rejects each
`timescale 1ns/1ps
`include "crs_defs.svh"
module crs_mem_gate
	import crs_pkg::*;
(
	input wire crs_mem_req_t req_in,
	input wire logic req_valid_in,
	output logic accept_out,
	output logic reject_out
);
	logic in_range;
	always_comb begin
		unique case (req_in.space)
			// only the top of the program space is fitted, so lower addresses are refused
			CRS_SP_PROG: in_range = !req_in.wr &&
				(req_in.addr >= 16'(32'h0001_0000 - `CRS_PROG_BYTES));
			CRS_SP_DATA: in_range = req_in.addr < 16'(`CRS_DATA_BYTES);
			CRS_SP_DISP: in_range = req_in.addr < 16'(`CRS_DISP_NIBBLES) &&
				req_in.wdata[7:4] == 4'h0;
			default: in_range = 1'b0;
		endcase
	end
	assign accept_out = req_valid_in && in_range;
	assign reject_out = req_valid_in && !in_range;
endmodule : crs_mem_gate

// >>> rtl/crs_core_regs.sv
// architectural register set of the 8-bit core
`timescale 1ns/1ps
`include "crs_defs.svh"
module crs_core_regs
	import crs_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire crs_cmd_t cmd_in,
	input wire logic cmd_valid_in,
	input wire logic call_in,
	input wire logic ret_in,
	input wire logic irq_accept_in,
	input wire logic [7:0] vec_data_in,
	input wire logic vec_valid_in,
	input wire logic [7:0] flags_in,
	input wire logic [7:0] flags_we_in,
	input wire logic index_sel_in,
	input wire logic [15:0] operand_addr_in,
	input wire crs_mem_req_t mem_req_in,
	input wire logic mem_req_valid_in,
	output logic [15:0] vec_addr_out,
	output logic vec_rd_out,
	output logic running_out,
	output logic [15:0] program_counter_out,
	output logic [7:0] acc_out,
	output logic [7:0] index_x_out,
	output logic [7:0] index_y_out,
	output logic [7:0] stack_pointer_out,
	output logic [15:0] stack_addr_out,
	output logic [7:0] processor_status_word_out,
	output logic [15:0] paired_wide_accumulator_out,
	output logic [15:0] eff_addr_out,
	output logic cmp_eq_out,
	output logic cmp_lt_out,
	output logic mem_accept_out,
	output logic mem_reject_out
);
	crs_state_s_t s_r;
	crs_state_s_t s_nxt;
	logic [7:0] sp_q;
	logic sp_load;
	logic [7:0] sp_d;
	logic [7:0] sel_val;

	function automatic logic [15:0] stack_addr(input logic [7:0] p);
		stack_addr = {`CRS_STACK_PAGE, p};
	endfunction : stack_addr

	function automatic logic [7:0] reg_of(input crs_state_s_t s, input crs_sel_t sel);
		unique case (sel)
			CRS_R_A: reg_of = s.a;
			CRS_R_X: reg_of = s.x;
			CRS_R_Y: reg_of = s.y;
			CRS_R_SP: reg_of = s.sp;
			default: reg_of = s.processor_status_word;
		endcase
	endfunction : reg_of

	always_comb begin
		sel_val = reg_of(s_r, cmd_in.sel);
		// the live stack pointer sits outside the state copy, which lags it by a cycle
		if (cmd_in.sel == CRS_R_SP) begin
			sel_val = sp_q;
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.sp = sp_q;
		sp_load = 1'b0;
		sp_d = sp_q;
		unique case (s_r.st)
			CRS_ST_RESET: s_nxt.st = CRS_ST_VLO;
			CRS_ST_VLO: begin
				if (vec_valid_in) begin
					s_nxt.vlo = vec_data_in;
					s_nxt.st = CRS_ST_VHI;
				end
			end
			CRS_ST_VHI: begin
				if (vec_valid_in) begin
					s_nxt.pc = {vec_data_in, s_r.vlo};
					s_nxt.st = CRS_ST_RUN;
				end
			end
			CRS_ST_RUN: begin
				if (irq_accept_in || call_in) begin
					sp_load = 1'b1;
					sp_d = sp_q - 8'h02;
					if (irq_accept_in) begin
						s_nxt.processor_status_word[`CRS_PSW_I] = 1'b0;
					end
				end else if (ret_in) begin
					sp_load = 1'b1;
					sp_d = sp_q + 8'h02;
				end
				for (int i = 0; i < 8; i++) begin
					if (flags_we_in[i]) begin
						s_nxt.processor_status_word[i] = flags_in[i];
					end
				end
				if (cmd_valid_in) begin
					unique case (cmd_in.op)
						CRS_OP_LD: begin
							unique case (cmd_in.sel)
								CRS_R_A: s_nxt.a = cmd_in.data;
								CRS_R_X: s_nxt.x = cmd_in.data;
								CRS_R_Y: s_nxt.y = cmd_in.data;
								CRS_R_SP: begin
									sp_load = 1'b1;
									sp_d = cmd_in.data;
								end
								default: s_nxt.processor_status_word = cmd_in.data;
							endcase
						end
						CRS_OP_INC, CRS_OP_DEC: begin
							unique case (cmd_in.sel)
								CRS_R_X: s_nxt.x = (cmd_in.op == CRS_OP_INC) ? s_r.x + 8'h01 :
									s_r.x - 8'h01;
								CRS_R_Y: s_nxt.y = (cmd_in.op == CRS_OP_INC) ? s_r.y + 8'h01 :
									s_r.y - 8'h01;
								default: s_nxt.a = (cmd_in.op == CRS_OP_INC) ? s_r.a + 8'h01 :
									s_r.a - 8'h01;
							endcase
						end
						CRS_OP_CMP: begin
							s_nxt.processor_status_word[`CRS_PSW_Z] = (sel_val == cmd_in.data);
							s_nxt.processor_status_word[`CRS_PSW_C] = (sel_val >= cmd_in.data);
						end
						CRS_OP_LDW: begin
							s_nxt.y = cmd_in.wide[15:8];
							s_nxt.a = cmd_in.wide[7:0];
						end
						CRS_OP_JMP: s_nxt.pc = cmd_in.wide;
						CRS_OP_STEP: s_nxt.pc = s_r.pc + 16'h0001;
						default: s_nxt.pc = s_r.pc;
					endcase
				end
			end
			default: s_nxt.st = CRS_ST_RESET;
		endcase
	end

	// stack pointer kept out of reset so software must load it
	always_ff @(posedge core_clk_in) begin
		if (sp_load) begin
			sp_q <= sp_d;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r.st <= CRS_ST_RESET;
			s_r.pc <= `CRS_RESET_VEC_LO;
			s_r.a <= 8'h00;
			s_r.x <= 8'h00;
			s_r.y <= 8'h00;
			s_r.sp <= 8'h00;
			s_r.processor_status_word <= `CRS_PSW_RST;
			s_r.vlo <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	crs_mem_gate u_gate (
		.req_in(mem_req_in),
		.req_valid_in(mem_req_valid_in),
		.accept_out(mem_accept_out),
		.reject_out(mem_reject_out)
	);

	assign vec_addr_out = (s_r.st == CRS_ST_VHI) ? `CRS_RESET_VEC_HI : `CRS_RESET_VEC_LO;
	assign vec_rd_out = (s_r.st == CRS_ST_VLO) || (s_r.st == CRS_ST_VHI);
	assign running_out = (s_r.st == CRS_ST_RUN);
	assign program_counter_out = s_r.pc;
	assign acc_out = s_r.a;
	assign index_x_out = s_r.x;
	assign index_y_out = s_r.y;
	assign stack_pointer_out = sp_q;
	assign stack_addr_out = stack_addr(sp_q);
	assign processor_status_word_out = s_r.processor_status_word;
	assign paired_wide_accumulator_out = {s_r.y, s_r.a};
	assign eff_addr_out = operand_addr_in + {8'h00, index_sel_in ? s_r.y : s_r.x};
	assign cmp_eq_out = (sel_val == cmd_in.data);
	assign cmp_lt_out = (sel_val < cmd_in.data);

	sequence vec_lo_taken_s;
		s_r.st == CRS_ST_VLO && vec_valid_in;
	endsequence
	sequence vec_hi_taken_s;
		s_r.st == CRS_ST_VHI && vec_valid_in;
	endsequence

	vector_low_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		vec_lo_taken_s |=> s_r.st == CRS_ST_VHI && vec_addr_out == `CRS_RESET_VEC_HI)
		else $error("low vector byte not taken");
	vector_order_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		vec_hi_taken_s |=> program_counter_out == {$past(vec_data_in), $past(s_r.vlo)}
		&& running_out) else $error("pc not loaded from vector");
	pair_order_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(running_out && cmd_valid_in && cmd_in.op == CRS_OP_LDW)
		|=> paired_wide_accumulator_out == $past(cmd_in.wide)) else $error("wide pair wrong");
	sp_call_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(running_out && (call_in || irq_accept_in) && !cmd_valid_in)
		|=> stack_pointer_out == $past(stack_pointer_out) - 8'h02)
		else $error("stack pointer not moved");
	stack_page_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		stack_addr_out[15:8] == `CRS_STACK_PAGE) else $error("stack outside page");
	index_addr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!index_sel_in |-> eff_addr_out == operand_addr_in + {8'h00, index_x_out})
		else $error("bad index address");
	index_inc_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(running_out && cmd_valid_in && cmd_in.op == CRS_OP_INC && cmd_in.sel == CRS_R_X)
		|=> index_x_out == $past(index_x_out) + 8'h01) else $error("index increment failed");
	prog_wr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(mem_req_valid_in && mem_req_in.space == CRS_SP_PROG && mem_req_in.wr)
		|-> mem_reject_out) else $error("program write accepted");
	disp_range_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(mem_req_valid_in && mem_req_in.space == CRS_SP_DISP && mem_req_in.addr >= 16'h001B)
		|-> !mem_accept_out) else $error("display beyond 27 nibbles");
	data_range_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(mem_req_valid_in && mem_req_in.space == CRS_SP_DATA)
		|-> mem_accept_out == (mem_req_in.addr < 16'h0400)) else $error("data range wrong");
	irq_flag_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(running_out && irq_accept_in && !flags_we_in[`CRS_PSW_I]
		&& !(cmd_valid_in && cmd_in.op == CRS_OP_LD && cmd_in.sel == CRS_R_PSW))
		|=> !processor_status_word_out[`CRS_PSW_I]) else $error("interrupt flag not cleared");
endmodule : crs_core_regs

// >>> tb/cpu_core_register_set_tb_top.sv
// self-checking bench for the core register set
`timescale 1ns/1ps
`include "crs_defs.svh"
module cpu_core_register_set_tb_top
	import crs_pkg::*;
;
	logic core_clk_in, rst_n_in, cmd_valid_in, call_in, ret_in, irq_accept_in;
	logic vec_valid_in, index_sel_in, mem_req_valid_in;
	logic [7:0] vec_data_in, flags_in, flags_we_in;
	logic [15:0] operand_addr_in;
	crs_cmd_t cmd_in;
	crs_mem_req_t mem_req_in;
	logic [15:0] vec_addr_out, program_counter_out, stack_addr_out;
	logic [15:0] paired_wide_accumulator_out, eff_addr_out;
	logic [7:0] acc_out, index_x_out, index_y_out, stack_pointer_out;
	logic [7:0] processor_status_word_out;
	logic vec_rd_out, running_out, cmp_eq_out, cmp_lt_out, mem_accept_out, mem_reject_out;
	int miscompares = 0;
	int total_checks = 0;
	crs_core_regs dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
		.cmd_valid_in(cmd_valid_in), .call_in(call_in), .ret_in(ret_in),
		.irq_accept_in(irq_accept_in), .vec_data_in(vec_data_in), .vec_valid_in(vec_valid_in),
		.flags_in(flags_in), .flags_we_in(flags_we_in), .index_sel_in(index_sel_in),
		.operand_addr_in(operand_addr_in), .mem_req_in(mem_req_in),
		.mem_req_valid_in(mem_req_valid_in), .vec_addr_out(vec_addr_out),
		.vec_rd_out(vec_rd_out), .running_out(running_out),
		.program_counter_out(program_counter_out), .acc_out(acc_out),
		.index_x_out(index_x_out), .index_y_out(index_y_out),
		.stack_pointer_out(stack_pointer_out), .stack_addr_out(stack_addr_out),
		.processor_status_word_out(processor_status_word_out),
		.paired_wide_accumulator_out(paired_wide_accumulator_out),
		.eff_addr_out(eff_addr_out), .cmp_eq_out(cmp_eq_out), .cmp_lt_out(cmp_lt_out),
		.mem_accept_out(mem_accept_out), .mem_reject_out(mem_reject_out));
	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// one-cycle command, with an idle cycle after so valid never toggles twice in a step
	task automatic cmd(input crs_op_t op, input crs_sel_t sel, input logic [7:0] d,
		input logic [15:0] w);
		@(negedge core_clk_in);
		cmd_in = '{op: op, sel: sel, data: d, wide: w};
		cmd_valid_in = 1'b1;
		@(negedge core_clk_in);
		cmd_valid_in = 1'b0;
	endtask : cmd
	task automatic pulse(input int kind);
		@(negedge core_clk_in);
		call_in = (kind == 0);
		ret_in = (kind == 1);
		irq_accept_in = (kind == 2);
		@(negedge core_clk_in);
		{call_in, ret_in, irq_accept_in} = 3'h0;
	endtask : pulse
	task automatic mreq(input crs_space_t s, input logic wr, input logic [15:0] a,
		input logic [7:0] d, input logic acc);
		@(negedge core_clk_in);
		mem_req_in = '{space: s, wr: wr, addr: a, wdata: d};
		mem_req_valid_in = 1'b1;
		#1;
		chk({15'h0, mem_accept_out}, {15'h0, acc}, "mem accept");
		chk({15'h0, mem_reject_out}, {15'h0, ~acc}, "mem reject");
	endtask : mreq
	task automatic test_reset_vector();
		chk(program_counter_out, `CRS_RESET_VEC_LO, "pc in reset");
		chk({acc_out, index_x_out}, 16'h0000, "a x in reset");
		chk({index_y_out, processor_status_word_out}, 16'h0000, "y psw in reset");
		chk({15'h0, vec_rd_out}, 16'h0000, "vec rd in reset");
		rst_n_in = 1'b1;
		@(negedge core_clk_in);
		chk({15'h0, vec_rd_out}, 16'h0001, "vec rd low");
		chk(vec_addr_out, 16'hFFFE, "vec addr low");
		vec_valid_in = 1'b1;
		vec_data_in = 8'h00;
		@(negedge core_clk_in);
		chk(vec_addr_out, 16'hFFFF, "vec addr high");
		vec_data_in = 8'hE0;
		@(negedge core_clk_in);
		vec_valid_in = 1'b0;
		chk({15'h0, running_out}, 16'h0001, "running");
		chk(program_counter_out, 16'hE000, "pc from vector");
	endtask : test_reset_vector
	task automatic test_wide_index();
		cmd(CRS_OP_LDW, CRS_R_A, 8'h00, 16'h1234);
		chk({index_y_out, acc_out}, 16'h1234, "pair halves");
		chk(paired_wide_accumulator_out, 16'h1234, "pair");
		cmd(CRS_OP_LD, CRS_R_A, 8'hC3, 16'h0000);
		chk({8'h00, acc_out}, 16'h00C3, "acc load");
		cmd(CRS_OP_LD, CRS_R_X, 8'h7F, 16'h0000);
		cmd(CRS_OP_INC, CRS_R_X, 8'h00, 16'h0000);
		chk({8'h00, index_x_out}, 16'h0080, "x inc");
		cmd(CRS_OP_DEC, CRS_R_X, 8'h00, 16'h0000);
		cmd(CRS_OP_DEC, CRS_R_X, 8'h00, 16'h0000);
		chk({8'h00, index_x_out}, 16'h007E, "x dec");
		cmd(CRS_OP_INC, CRS_R_Y, 8'h00, 16'h0000);
		chk({8'h00, index_y_out}, 16'h0013, "y inc");
		@(negedge core_clk_in);
		cmd_in = '{op: CRS_OP_CMP, sel: CRS_R_X, data: 8'h7E, wide: 16'h0000};
		#1;
		chk({14'h0, cmp_eq_out, cmp_lt_out}, 16'h0002, "cmp equal");
		@(negedge core_clk_in);
		cmd_in.data = 8'h7F;
		#1;
		chk({14'h0, cmp_eq_out, cmp_lt_out}, 16'h0001, "cmp less");
		@(negedge core_clk_in);
		operand_addr_in = 16'h2000;
		index_sel_in = 1'b0;
		#1;
		chk(eff_addr_out, 16'h207E, "indexed x");
		@(negedge core_clk_in);
		index_sel_in = 1'b1;
		#1;
		chk(eff_addr_out, 16'h2013, "indexed y");
	endtask : test_wide_index
	task automatic test_flags_stack();
		@(negedge core_clk_in);
		flags_in = 8'hA5;
		flags_we_in = 8'hFF;
		@(negedge core_clk_in);
		flags_in = 8'h00;
		flags_we_in = 8'h01;
		chk({8'h00, processor_status_word_out}, 16'h00A5, "flags all");
		@(negedge core_clk_in);
		flags_we_in = 8'h00;
		chk({8'h00, processor_status_word_out}, 16'h00A4, "flag carry only");
		cmd(CRS_OP_LD, CRS_R_PSW, 8'h3C, 16'h0000);
		cmd(CRS_OP_LD, CRS_R_SP, 8'h5F, 16'h0000);
		chk(stack_addr_out, `CRS_STACK_TOP, "stack top");
		pulse(0);
		chk({8'h00, stack_pointer_out}, 16'h005D, "call");
		pulse(2);
		chk(stack_addr_out, 16'h015B, "irq");
		chk({8'h00, processor_status_word_out}, 16'h0038, "irq masks");
		pulse(1);
		chk({8'h00, stack_pointer_out}, 16'h005D, "ret");
	endtask : test_flags_stack
	task automatic test_run_reset();
		cmd(CRS_OP_JMP, CRS_R_A, 8'h00, 16'hE123);
		chk(program_counter_out, 16'hE123, "jump");
		cmd(CRS_OP_STEP, CRS_R_A, 8'h00, 16'h0000);
		chk(program_counter_out, 16'hE124, "step");
		cmd(CRS_OP_INC, CRS_R_A, 8'h00, 16'h0000);
		chk({8'h00, acc_out}, 16'h00C4, "acc inc");
		cmd(CRS_OP_LD, CRS_R_Y, 8'h40, 16'h0000);
		chk(paired_wide_accumulator_out, 16'h40C4, "pair after y load");
		cmd(CRS_OP_CMP, CRS_R_Y, 8'h40, 16'h0000);
		chk({8'h00, processor_status_word_out}, 16'h003B, "cmp flags equal");
		cmd(CRS_OP_CMP, CRS_R_Y, 8'h41, 16'h0000);
		chk({8'h00, processor_status_word_out}, 16'h0038, "cmp flags below");
		@(negedge core_clk_in);
		cmd_in = '{op: CRS_OP_CMP, sel: CRS_R_SP, data: 8'h5D, wide: 16'h0000};
		#1;
		chk({14'h0, cmp_eq_out, cmp_lt_out}, 16'h0002, "cmp stack pointer");
		@(negedge core_clk_in);
		rst_n_in = 1'b0;
		@(negedge core_clk_in);
		rst_n_in = 1'b1;
		chk(program_counter_out, `CRS_RESET_VEC_LO, "pc after reset");
		chk({8'h00, stack_pointer_out}, 16'h005D, "sp kept over reset");
		cmd(CRS_OP_LD, CRS_R_A, 8'h55, 16'h0000);
		chk({acc_out, 7'h00, running_out}, 16'h0000, "no command before vector");
	endtask : test_run_reset
	task automatic test_spaces();
		mreq(CRS_SP_PROG, 1'b0, 16'hE000, 8'h00, 1'b1);
		mreq(CRS_SP_PROG, 1'b0, 16'h1FFF, 8'h00, 1'b0);
		mreq(CRS_SP_PROG, 1'b1, 16'hE000, 8'h00, 1'b0);
		mreq(CRS_SP_DATA, 1'b1, 16'h03FF, 8'h5A, 1'b1);
		mreq(CRS_SP_DATA, 1'b0, 16'h0400, 8'h00, 1'b0);
		mreq(CRS_SP_DISP, 1'b1, 16'h001A, 8'h0F, 1'b1);
		mreq(CRS_SP_DISP, 1'b1, 16'h001B, 8'h0F, 1'b0);
		mreq(CRS_SP_DISP, 1'b1, 16'h0000, 8'h10, 1'b0);
		@(negedge core_clk_in);
		mem_req_valid_in = 1'b0;
	endtask : test_spaces
	initial begin
		rst_n_in = 1'b0;
		{cmd_valid_in, call_in, ret_in, irq_accept_in, vec_valid_in} = 5'h00;
		{index_sel_in, mem_req_valid_in} = 2'h0;
		{vec_data_in, flags_in, flags_we_in} = 24'h000000;
		operand_addr_in = 16'h0000;
		cmd_in = '{op: CRS_OP_NONE, sel: CRS_R_A, data: 8'h00, wide: 16'h0000};
		mem_req_in = '{space: CRS_SP_PROG, wr: 1'b0, addr: 16'h0000, wdata: 8'h00};
		repeat (12) @(negedge core_clk_in);
		test_reset_vector();
		test_wide_index();
		test_flags_stack();
		test_run_reset();
		test_spaces();
		final_report();
	end
	// the whole sequence needs well under 200 cycles
	initial begin
		#10000;
		miscompares++;
		final_report();
	end
endmodule : cpu_core_register_set_tb_top
